// ### logic/rcc_config_regs.sv
// Purpose: Per-channel configuration register bank of a repeater lane pair
// Assumes: Management engine presents byte reads and writes on a simple register port
// Notes: Analog consumers read the registered control outputs
// Function
// R1: Idle-select 0 keeps output driving, squelch off; 1 forces muted electrical idle.
// R2: Rate-auto 0 uses rate-select bit; rate-auto 1 detects rate automatically.
// R3: Rate-select 0 picks 2.5-3.2 Gbps, 1 picks 5.0-6.4 Gbps range.
// R4: Equalizer: bit5 enable, bits4:3 gain stage, bits2:0 boost; 32 levels.
// R5: Equalizer register resets to 0x20, bypass.
// R6: Strap pin pairs map to fixed equalizer codes.
// R7: Swing codes 03,07,0F,1F,3F give 600..1400 mV; reset 0x03.
// R8: De-emphasis bit7 selects compatibility or enhanced; bits6:0 level.
// R9: De-emphasis codes decode to 0,-3.5,-6,-9,-12 dB; C0 reserved; reset 0x03.
// R10: Threshold bits3:2 de-assert, bits1:0 assert, each from four-entry table.
// R11: Threshold codes select 110/70..190/150 mV; field resets to 00.
// R12: Idle-auto 0 obeys idle-select; idle-auto 1 detects idle automatically.
// R13: Idle/rate control sits at 0x39, bits7:6 reserved, resets 0x00.
// R14: Host writes zeros to reserved bits, never the reserved de-emphasis code.
`timescale 1ns/1ps
`include "rcc_regs.svh"

module rcc_config_regs
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port from the management engine
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Strap pins, asynchronous
    input wire logic reg_mode_i,
    input wire logic [1:0] equalizer_strap_a_i,
    input wire logic [1:0] equalizer_strap_b_i,
    // Idle and rate controls
    output logic mute_o,
    output logic signal_presence_gate_o,
    output logic rate_auto_o,
    output logic rate_high_o,
    // Equalizer
    output logic eq_enable_o,
    output logic [1:0] gain_stage_field_o,
    output logic [2:0] boost_level_field_o,
    // Driver
    output logic [10:0] output_swing_mv_o,
    output logic tx_preshaping_enhanced_o,
    output logic [6:0] tx_preshaping_level_o,
    output rcc_pkg::rcc_deemph_t tx_preshaping_db_o,
    output logic tx_preshaping_reserved_o,
    // Idle detect thresholds
    output logic [7:0] thr_deassert_mv_o,
    output logic [7:0] thr_assert_mv_o,
    // Neighbouring channel control byte
    output logic [7:0] ch7_idle_rate_control_o
);

    logic [7:0] ch6_idle_rate_control;
    logic [7:0] ch6_equalizer_setting;
    logic [7:0] ch6_output_swing;
    logic [7:0] ch6_deemphasis_setting;
    logic [7:0] ch6_idle_threshold;
    logic [7:0] ch7_idle_rate_control;
    logic [4:0] strap_meta;
    logic [4:0] strap_sync;
    logic [5:0] strap_eq_code;
    logic [5:0] next_eq_code;
    logic [10:0] swing_mv;
    rcc_pkg::rcc_deemph_t deemph_level;
    logic [7:0] thr_deassert;
    logic [7:0] thr_assert;

    // Pins cross from outside, two flops before use
    // Reset to register mode so eq holds bypass, not a strap code
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            strap_meta <= `RCC_RST_STRAP;
            strap_sync <= `RCC_RST_STRAP;
        end
        else
        begin
            strap_meta <= {reg_mode_i, equalizer_strap_a_i, equalizer_strap_b_i};
            strap_sync <= strap_meta;
        end
    end

    // R13: idle/rate control
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            ch6_idle_rate_control <= `RCC_RST_IDLE_RATE;
        else if (reg_wr_i && reg_addr_i == `RCC_OFS_CH6_IDLE_RATE)
            ch6_idle_rate_control <= reg_wdata_i;
    end

    // R5: equalizer reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            ch6_equalizer_setting <= `RCC_RST_EQ;
        else if (reg_wr_i && reg_addr_i == `RCC_OFS_CH6_EQ)
            ch6_equalizer_setting <= reg_wdata_i;
    end

    // R7: swing, upper bits read-only
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            ch6_output_swing <= `RCC_RST_SWING;
        else if (reg_wr_i && reg_addr_i == `RCC_OFS_CH6_SWING)
            ch6_output_swing <= reg_wdata_i & `RCC_SWING_MASK;
    end

    // R9: de-emphasis reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            ch6_deemphasis_setting <= `RCC_RST_DEEMPH;
        else if (reg_wr_i && reg_addr_i == `RCC_OFS_CH6_DEEMPH)
            ch6_deemphasis_setting <= reg_wdata_i;
    end

    // R11: threshold reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            ch6_idle_threshold <= `RCC_RST_THRESH;
        else if (reg_wr_i && reg_addr_i == `RCC_OFS_CH6_THRESH)
            ch6_idle_threshold <= reg_wdata_i;
    end

    // Stored only; the next channel's logic consumes it
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            ch7_idle_rate_control <= `RCC_RST_IDLE_RATE;
        else if (reg_wr_i && reg_addr_i == `RCC_OFS_CH7_IDLE_RATE)
            ch7_idle_rate_control <= reg_wdata_i;
    end

    // Read data, registered; unmapped offsets read zero
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= `RCC_UNMAPPED_READ;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `RCC_OFS_CH6_IDLE_RATE: reg_rdata_o <= ch6_idle_rate_control;
                `RCC_OFS_CH6_EQ: reg_rdata_o <= ch6_equalizer_setting;
                `RCC_OFS_CH6_SWING: reg_rdata_o <= ch6_output_swing;
                `RCC_OFS_CH6_DEEMPH: reg_rdata_o <= ch6_deemphasis_setting;
                `RCC_OFS_CH6_THRESH: reg_rdata_o <= ch6_idle_threshold;
                `RCC_OFS_CH7_IDLE_RATE: reg_rdata_o <= ch7_idle_rate_control;
                default: reg_rdata_o <= `RCC_UNMAPPED_READ;
            endcase
        end
    end

    rcc_decode u_decode
    (
        .equalizer_strap_a_i(strap_sync[3:2]),
        .equalizer_strap_b_i(strap_sync[1:0]),
        .swing_code_i(ch6_output_swing),
        .deemph_code_i(ch6_deemphasis_setting),
        .thresh_field_i(ch6_idle_threshold[3:0]),
        .strap_eq_code_o(strap_eq_code),
        .swing_mv_o(swing_mv),
        .deemph_level_o(deemph_level),
        .thr_deassert_mv_o(thr_deassert),
        .thr_assert_mv_o(thr_assert)
    );

    // R6: straps rule when register mode is off
    assign next_eq_code = strap_sync[4] ? ch6_equalizer_setting[5:0] : strap_eq_code;

    // Decoded controls, registered
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            mute_o <= 1'b0;
            signal_presence_gate_o <= 1'b0;
            rate_auto_o <= 1'b0;
            rate_high_o <= 1'b0;
            eq_enable_o <= 1'b1;
            gain_stage_field_o <= 2'h0;
            boost_level_field_o <= 3'h0;
            output_swing_mv_o <= 11'd600;
            tx_preshaping_enhanced_o <= 1'b0;
            tx_preshaping_level_o <= 7'h03;
            tx_preshaping_db_o <= rcc_pkg::RCC_DE_CUSTOM;
            tx_preshaping_reserved_o <= 1'b0;
            thr_deassert_mv_o <= 8'd110;
            thr_assert_mv_o <= 8'd70;
            ch7_idle_rate_control_o <= `RCC_RST_IDLE_RATE;
        end
        else
        begin
            // R1: forced mute
            // R12: auto idle wins
            mute_o <= !ch6_idle_rate_control[`RCC_BIT_IDLE_AUTO] && ch6_idle_rate_control[`RCC_BIT_IDLE_SEL];
            signal_presence_gate_o <= ch6_idle_rate_control[`RCC_BIT_IDLE_AUTO];
            // R2: rate source
            rate_auto_o <= ch6_idle_rate_control[`RCC_BIT_RATE_AUTO];
            // R3: manual range
            rate_high_o <= !ch6_idle_rate_control[`RCC_BIT_RATE_AUTO] && ch6_idle_rate_control[`RCC_BIT_RATE_SEL];
            // R4: equalizer split
            eq_enable_o <= next_eq_code[`RCC_BIT_EQ_EN];
            gain_stage_field_o <= next_eq_code[`RCC_EQ_GAIN_HI:`RCC_EQ_GAIN_LO];
            boost_level_field_o <= next_eq_code[`RCC_EQ_BOOST_HI:`RCC_EQ_BOOST_LO];
            output_swing_mv_o <= swing_mv;
            // R8: type and level
            tx_preshaping_enhanced_o <= ch6_deemphasis_setting[`RCC_BIT_DE_TYPE];
            tx_preshaping_level_o <= ch6_deemphasis_setting[`RCC_DE_LEVEL_HI:0];
            tx_preshaping_db_o <= deemph_level;
            // R14: reserved code flagged
            tx_preshaping_reserved_o <= (deemph_level == rcc_pkg::RCC_DE_RESERVED);
            // R10: threshold pair
            thr_deassert_mv_o <= thr_deassert;
            thr_assert_mv_o <= thr_assert;
            ch7_idle_rate_control_o <= ch7_idle_rate_control;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    reset_values_a: assert property ($past(sys_rst_i) |-> ch6_equalizer_setting == 8'h20 && ch6_output_swing == 8'h03 // R5
        && ch6_deemphasis_setting == 8'h03 && ch6_idle_threshold == 8'h00 && ch6_idle_rate_control == 8'h00)
        else $error("reset values wrong");
    mute_force_a: assert property (ch6_idle_rate_control[5:4] == 2'b01 |=> mute_o && !signal_presence_gate_o) // R1
        else $error("mute not forced");
    idle_auto_a: assert property (ch6_idle_rate_control[5] |=> !mute_o && signal_presence_gate_o) // R12
        else $error("auto idle not honoured");
    rate_manual_a: assert property (!ch6_idle_rate_control[1] |=> rate_high_o == $past(ch6_idle_rate_control[0])) // R2
        else $error("manual rate wrong");
    eq_split_a: assert property (strap_sync[4] |=> {eq_enable_o, gain_stage_field_o, boost_level_field_o} // R4
        == $past(ch6_equalizer_setting[5:0]))
        else $error("equalizer split wrong");
    strap_float_a: assert property ((!strap_sync[4] && strap_sync[3:0] == 4'hA) [*2] |=> eq_enable_o // R6
        && gain_stage_field_o == 2'h0 && boost_level_field_o == 3'h0) else $error("strap bypass wrong");
    swing_map_a: assert property (ch6_output_swing == 8'h0F |=> output_swing_mv_o == 11'd1000) // R7
        else $error("swing map wrong");
    deemph_map_a: assert property (ch6_deemphasis_setting == 8'hA0 |=> tx_preshaping_db_o == rcc_pkg::RCC_DE_M12 // R9
        && tx_preshaping_enhanced_o) else $error("de-emphasis map wrong");
    thresh_map_a: assert property (ch6_idle_threshold[3:0] == 4'hE |=> thr_deassert_mv_o == 8'd190 // R11
        && thr_assert_mv_o == 8'd130) else $error("threshold map wrong");
    ctrl_readback_a: assert property (reg_wr_i && reg_addr_i == 8'h39 ##1 !reg_wr_i ##1 reg_rd_i // R13
        && reg_addr_i == 8'h39 && !reg_wr_i |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("control readback wrong");

    mute_seen_c: cover property (!mute_o ##1 mute_o);
    reserved_seen_c: cover property (tx_preshaping_reserved_o);
    strap_mode_c: cover property (!strap_sync[4] ##1 eq_enable_o && gain_stage_field_o == 2'h3);

endmodule // rcc_config_regs

// ### logic/rcc_decode.sv
// Purpose: Combinational decode of strap pins and register codes
// Assumes: Strap inputs already synchronised
// Notes: Results are registered by the caller
`timescale 1ns/1ps
`include "rcc_regs.svh"

module rcc_decode
(
    // Strap pins
    input wire logic [1:0] equalizer_strap_a_i,
    input wire logic [1:0] equalizer_strap_b_i,
    // Register codes
    input wire logic [7:0] swing_code_i,
    input wire logic [7:0] deemph_code_i,
    input wire logic [3:0] thresh_field_i,
    // Decoded values
    output logic [5:0] strap_eq_code_o,
    output logic [10:0] swing_mv_o,
    output rcc_pkg::rcc_deemph_t deemph_level_o,
    output logic [7:0] thr_deassert_mv_o,
    output logic [7:0] thr_assert_mv_o
);

    // R6: strap to code
    always_comb
    begin
        unique case ({equalizer_strap_a_i, equalizer_strap_b_i})
            {`RCC_STRAP_HIGH, `RCC_STRAP_HIGH}: strap_eq_code_o = 6'h2A;
            {`RCC_STRAP_LOW, `RCC_STRAP_LOW}: strap_eq_code_o = 6'h30;
            {`RCC_STRAP_LOW, `RCC_STRAP_FLOAT}: strap_eq_code_o = 6'h31;
            {`RCC_STRAP_LOW, `RCC_STRAP_HIGH}: strap_eq_code_o = 6'h38;
            {`RCC_STRAP_HIGH, `RCC_STRAP_FLOAT}: strap_eq_code_o = 6'h34;
            {`RCC_STRAP_HIGH, `RCC_STRAP_LOW}: strap_eq_code_o = 6'h35;
            {`RCC_STRAP_FLOAT, `RCC_STRAP_LOW}: strap_eq_code_o = 6'h3A;
            {`RCC_STRAP_FLOAT, `RCC_STRAP_HIGH}: strap_eq_code_o = 6'h3C;
            // Both floating, or an illegal encoding, means bypass
            default: strap_eq_code_o = 6'h20;
        endcase
    end

    // R7: swing code map
    always_comb
    begin
        unique case (swing_code_i)
            `RCC_SWING_600: swing_mv_o = 11'd600;
            `RCC_SWING_800: swing_mv_o = 11'd800;
            `RCC_SWING_1000: swing_mv_o = 11'd1000;
            `RCC_SWING_1200: swing_mv_o = 11'd1200;
            `RCC_SWING_1400: swing_mv_o = 11'd1400;
            // Undefined codes report zero so the driver can flag them
            default: swing_mv_o = 11'd0;
        endcase
    end

    // R9: de-emphasis code map
    always_comb
    begin
        unique case (deemph_code_i)
            `RCC_DE_CODE_0DB: deemph_level_o = rcc_pkg::RCC_DE_0DB;
            `RCC_DE_CODE_M3P5: deemph_level_o = rcc_pkg::RCC_DE_M3P5;
            `RCC_DE_CODE_M6: deemph_level_o = rcc_pkg::RCC_DE_M6;
            `RCC_DE_CODE_M9: deemph_level_o = rcc_pkg::RCC_DE_M9;
            `RCC_DE_CODE_M12: deemph_level_o = rcc_pkg::RCC_DE_M12;
            `RCC_DE_CODE_RSVD: deemph_level_o = rcc_pkg::RCC_DE_RESERVED;
            default: deemph_level_o = rcc_pkg::RCC_DE_CUSTOM;
        endcase
    end

    // R10: two threshold fields
    logic [7:0] thr_mv [2];
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_thr
            logic [1:0] code;
            assign code = thresh_field_i[2*gi+1 -: 2];
            // R11: threshold table
            assign thr_mv[gi] = (gi == 1) ? `RCC_THR_DEASSERT(code) : `RCC_THR_ASSERT(code);
        end
    endgenerate
    assign thr_deassert_mv_o = thr_mv[1];
    assign thr_assert_mv_o = thr_mv[0];

endmodule // rcc_decode

// ### logic/rcc_pkg.sv
// Purpose: Types shared by the channel config bank
// Assumes: Nothing
// Notes: Constants live in rcc_regs.svh
package rcc_pkg;

    typedef enum logic [2:0] {
        RCC_DE_0DB,
        RCC_DE_M3P5,
        RCC_DE_M6,
        RCC_DE_M9,
        RCC_DE_M12,
        RCC_DE_RESERVED,
        RCC_DE_CUSTOM
    } rcc_deemph_t;

endpackage

// ### logic/rcc_regs.svh
// Purpose: Offsets, field positions, reset values and decode tables of the channel config bank
// Assumes: Byte-wide registers at their printed offsets on an 8-bit register address
// Notes: Definitions only
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH

// Register offsets
`define RCC_OFS_CH6_IDLE_RATE 8'h39
`define RCC_OFS_CH6_EQ 8'h3A
`define RCC_OFS_CH6_SWING 8'h3B
`define RCC_OFS_CH6_DEEMPH 8'h3C
`define RCC_OFS_CH6_THRESH 8'h3D
`define RCC_OFS_CH7_IDLE_RATE 8'h40

// Reset values
`define RCC_RST_IDLE_RATE 8'h00
`define RCC_RST_EQ 8'h20
`define RCC_RST_SWING 8'h03
`define RCC_RST_DEEMPH 8'h03
`define RCC_RST_THRESH 8'h00
`define RCC_UNMAPPED_READ 8'h00
// Strap synchroniser: register mode, both straps floating
`define RCC_RST_STRAP 5'h1A

// Idle/rate control fields
`define RCC_BIT_IDLE_AUTO 5
`define RCC_BIT_IDLE_SEL 4
`define RCC_BIT_RATE_AUTO 1
`define RCC_BIT_RATE_SEL 0

// Equalizer fields
`define RCC_BIT_EQ_EN 5
`define RCC_EQ_GAIN_HI 4
`define RCC_EQ_GAIN_LO 3
`define RCC_EQ_BOOST_HI 2
`define RCC_EQ_BOOST_LO 0

// Swing field and writable mask (bits 7:6 read-only zero)
`define RCC_SWING_MASK 8'h3F
`define RCC_SWING_600 8'h03
`define RCC_SWING_800 8'h07
`define RCC_SWING_1000 8'h0F
`define RCC_SWING_1200 8'h1F
`define RCC_SWING_1400 8'h3F

// De-emphasis fields and codes
`define RCC_BIT_DE_TYPE 7
`define RCC_DE_LEVEL_HI 6
`define RCC_DE_CODE_0DB 8'h01
`define RCC_DE_CODE_M3P5 8'h38
`define RCC_DE_CODE_M6 8'h88
`define RCC_DE_CODE_M9 8'h90
`define RCC_DE_CODE_M12 8'hA0
`define RCC_DE_CODE_RSVD 8'hC0

// Strap pin encodings (per pin: low, high, floating)
`define RCC_STRAP_LOW 2'h0
`define RCC_STRAP_HIGH 2'h1
`define RCC_STRAP_FLOAT 2'h2

// Idle thresholds in mV, de-assert and assert per two-bit code
`define RCC_THR_DEASSERT(c) ((c) == 2'h0 ? 8'd110 : (c) == 2'h1 ? 8'd150 : (c) == 2'h2 ? 8'd170 : 8'd190)
`define RCC_THR_ASSERT(c) ((c) == 2'h0 ? 8'd70 : (c) == 2'h1 ? 8'd110 : (c) == 2'h2 ? 8'd130 : 8'd150)

`endif

// ### verification/rcc_config_regs_tb.sv
// Purpose: Self-checking bench of the channel config register bank
// Assumes: Host model drives the register port
// Notes: Strap mode is entered briefly, then register mode resumes
`timescale 1ns/1ps
`include "rcc_regs.svh"

module rcc_config_regs_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reg_mode = 1'b1;
    logic [1:0] strap_a = 2'h2;
    logic [1:0] strap_b = 2'h2;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, thr_de, thr_as, ch7_byte, rd_val;
    logic reg_wr, reg_rd, mute, gate, rate_auto, rate_high, eq_en, pre_enh, pre_rsvd;
    logic [1:0] gain;
    logic [2:0] boost;
    logic [10:0] swing_mv;
    logic [6:0] pre_lvl;
    rcc_pkg::rcc_deemph_t pre_db;
    int n_fail = 0;
    int comparisons = 0;

    always #4 clk_i = ~clk_i;

    rcc_host_model u_rcc_host_model (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

    rcc_config_regs u_rcc_config_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .reg_mode_i(reg_mode), .equalizer_strap_a_i(strap_a), .equalizer_strap_b_i(strap_b),
        .mute_o(mute), .signal_presence_gate_o(gate), .rate_auto_o(rate_auto), .rate_high_o(rate_high),
        .eq_enable_o(eq_en), .gain_stage_field_o(gain), .boost_level_field_o(boost),
        .output_swing_mv_o(swing_mv), .tx_preshaping_enhanced_o(pre_enh), .tx_preshaping_level_o(pre_lvl),
        .tx_preshaping_db_o(pre_db), .tx_preshaping_reserved_o(pre_rsvd), .thr_deassert_mv_o(thr_de),
        .thr_assert_mv_o(thr_as), .ch7_idle_rate_control_o(ch7_byte));

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_mv(input string what, input logic [10:0] exp, input logic [10:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic chk_db(input rcc_pkg::rcc_deemph_t exp);
        comparisons++;
        if (pre_db !== exp)
        begin
            n_fail++;
            $display("ERROR preshaping_db expected %0d seen %0d", exp, pre_db);
        end
    endtask

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
        u_rcc_host_model.rd(addr, rd_val);
        chk_byte(what, exp, rd_val);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic do_reset;
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        settle();
    endtask

    task automatic t_reset_values;
        chk_byte("mute_gate", 8'h00, {6'h0, mute, gate});
        chk_byte("eq_fields", 8'h20, {2'h0, eq_en, gain, boost});
        chk_mv("swing_mv", 11'd600, swing_mv);
        chk_db(rcc_pkg::RCC_DE_CUSTOM);
        chk_mv("thr_deassert", 11'd110, {3'h0, thr_de});
        chk_mv("thr_assert", 11'd70, {3'h0, thr_as});
        rd_chk("idle_rate", `RCC_OFS_CH6_IDLE_RATE, 8'h00);
        rd_chk("equalizer", `RCC_OFS_CH6_EQ, 8'h20);
        rd_chk("swing", `RCC_OFS_CH6_SWING, 8'h03);
        rd_chk("deemph", `RCC_OFS_CH6_DEEMPH, 8'h03);
        rd_chk("thresh", `RCC_OFS_CH6_THRESH, 8'h00);
        rd_chk("ch7_idle_rate", `RCC_OFS_CH7_IDLE_RATE, 8'h00);
        $display("test reset_values done");
    endtask

    task automatic t_idle_rate;
        logic [7:0] d;
        for (int i = 0; i < 16; i++)
        begin
            d = {2'h0, i[3], i[2], 2'h0, i[1], i[0]};
            u_rcc_host_model.wr(`RCC_OFS_CH6_IDLE_RATE, d);
            settle();
            chk_byte("mute", {7'h0, !i[3] && i[2]}, {7'h0, mute});
            chk_byte("presence_gate", {7'h0, i[3]}, {7'h0, gate});
            chk_byte("rate_auto", {7'h0, i[1]}, {7'h0, rate_auto});
            chk_byte("rate_high", {7'h0, !i[1] && i[0]}, {7'h0, rate_high});
            rd_chk("idle_rate", `RCC_OFS_CH6_IDLE_RATE, d);
        end
        u_rcc_host_model.wr(`RCC_OFS_CH6_IDLE_RATE, 8'h22);
        rd_chk("idle_rate_b2b", `RCC_OFS_CH6_IDLE_RATE, 8'h22);
        u_rcc_host_model.wr(`RCC_OFS_CH7_IDLE_RATE, 8'h31);
        settle();
        chk_byte("ch7_byte", 8'h31, ch7_byte);
        $display("test idle_rate done");
    endtask

    task automatic t_equalizer;
        logic [7:0] codes [5] = '{8'h20, 8'h2A, 8'h35, 8'h3C, 8'h1F};
        foreach (codes[i])
        begin
            u_rcc_host_model.wr(`RCC_OFS_CH6_EQ, codes[i]);
            settle();
            chk_byte("eq_fields", codes[i], {2'h0, eq_en, gain, boost});
            rd_chk("equalizer", `RCC_OFS_CH6_EQ, codes[i]);
        end
        $display("test equalizer done");
    endtask

    task automatic t_straps;
        logic [1:0] sa [9] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
        logic [1:0] sb [9] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1};
        logic [7:0] ex [9] = '{8'h20, 8'h2A, 8'h30, 8'h31, 8'h38, 8'h34, 8'h35, 8'h3A, 8'h3C};
        @(posedge clk_i);
        reg_mode <= 1'b0;
        foreach (ex[i])
        begin
            @(posedge clk_i);
            strap_a <= sa[i];
            strap_b <= sb[i];
            repeat (4) @(posedge clk_i);
            #1;
            chk_byte("strap_eq", ex[i], {2'h0, eq_en, gain, boost});
        end
        @(posedge clk_i);
        reg_mode <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        chk_byte("eq_fields", 8'h1F, {2'h0, eq_en, gain, boost});
        $display("test straps done");
    endtask

    task automatic t_swing;
        logic [7:0] codes [7] = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'hFF, 8'h05};
        logic [10:0] mv [7] = '{11'd600, 11'd800, 11'd1000, 11'd1200, 11'd1400, 11'd1400, 11'd0};
        foreach (codes[i])
        begin
            u_rcc_host_model.wr(`RCC_OFS_CH6_SWING, codes[i]);
            settle();
            chk_mv("swing_mv", mv[i], swing_mv);
            rd_chk("swing", `RCC_OFS_CH6_SWING, codes[i] & 8'h3F);
        end
        $display("test swing done");
    endtask

    task automatic t_deemph;
        logic [7:0] codes [7] = '{8'h01, 8'h38, 8'h88, 8'h90, 8'hA0, 8'hC0, 8'h03};
        rcc_pkg::rcc_deemph_t db [7] = '{rcc_pkg::RCC_DE_0DB, rcc_pkg::RCC_DE_M3P5, rcc_pkg::RCC_DE_M6,
            rcc_pkg::RCC_DE_M9, rcc_pkg::RCC_DE_M12, rcc_pkg::RCC_DE_RESERVED, rcc_pkg::RCC_DE_CUSTOM};
        foreach (codes[i])
        begin
            u_rcc_host_model.wr(`RCC_OFS_CH6_DEEMPH, codes[i]);
            settle();
            chk_db(db[i]);
            chk_byte("preshaping_bits", codes[i], {pre_enh, pre_lvl});
            chk_byte("preshaping_rsvd", {7'h0, codes[i] == 8'hC0}, {7'h0, pre_rsvd});
            rd_chk("deemph", `RCC_OFS_CH6_DEEMPH, codes[i]);
        end
        $display("test deemph done");
    endtask

    task automatic t_thresh;
        logic [10:0] de [4] = '{11'd110, 11'd150, 11'd170, 11'd190};
        logic [10:0] as [4] = '{11'd70, 11'd110, 11'd130, 11'd150};
        for (int i = 0; i < 16; i++)
        begin
            u_rcc_host_model.wr(`RCC_OFS_CH6_THRESH, 8'(i));
            settle();
            chk_mv("thr_deassert", de[i[3:2]], {3'h0, thr_de});
            chk_mv("thr_assert", as[i[1:0]], {3'h0, thr_as});
        end
        $display("test thresh done");
    endtask

    task automatic t_unmapped_rereset;
        u_rcc_host_model.wr(8'h3E, 8'h55);
        rd_chk("unmapped", 8'h3E, `RCC_UNMAPPED_READ);
        rd_chk("thresh", `RCC_OFS_CH6_THRESH, 8'h0F);
        do_reset();
        rd_chk("equalizer", `RCC_OFS_CH6_EQ, 8'h20);
        rd_chk("deemph", `RCC_OFS_CH6_DEEMPH, 8'h03);
        $display("test unmapped_rereset done");
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Runs take well under this span
    initial
    begin
        #200000;
        n_fail++;
        wrap_up();
    end

    initial
    begin
        do_reset();
        t_reset_values();
        t_idle_rate();
        t_equalizer();
        t_straps();
        t_swing();
        t_deemph();
        t_thresh();
        t_unmapped_rereset();
        wrap_up();
    end
endmodule // rcc_config_regs_tb

// ### verification/rcc_host_model.sv
// Purpose: Management host model driving the channel config register port
// Assumes: One strobe cycle per request, launched just after a rising edge
// Notes: Released write data shows its inverse so stale values never pass
`timescale 1ns/1ps

module rcc_host_model
(
    // Clock
    input wire logic clk_i,
    // Register port
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'hFF;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~data;
    endtask

    // Data taken one edge after acceptance
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        reg_addr_o <= addr;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        @(posedge clk_i);
        data = reg_rdata_i;
    endtask
endmodule // rcc_host_model
